// ==== pkg/sfrmap_pkg.sv ====
package sfrmap_pkg;
  localparam int SFRMAP_ADDR_W = 8;
  localparam int SFRMAP_DATA_W = 8;
  // direct sfr window, upper half of the direct space
  localparam logic [7:0] SFRMAP_WIN_BASE = 8'h80;
  localparam logic [7:0] SFRMAP_WIN_LAST = 8'hff;
  localparam int SFRMAP_WIN_SIZE = 128;
  localparam int SFRMAP_AREA_CNT = 2;
  localparam logic [7:0] SFRMAP_SYSAREA_OFS = 8'h8f;
  localparam logic [7:0] SFRMAP_SYSAREA_RST = 8'h04;
  localparam int SFRMAP_SELBIT_POS = 0;
  localparam logic [7:0] SFRMAP_SYSAREA_RW_MASK = 8'h41;
  localparam logic [7:0] SFRMAP_SYSAREA_ONE_MASK = 8'h04;

  typedef enum logic [1:0] {
    SFRMAP_AREA_STD = 2'b01,
    SFRMAP_AREA_MAP = 2'b10
  } sfrmap_area_t;

  // cpu direct access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfrmap_req_t;

  // routed access toward one register area
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] idx;
    logic [7:0] wdata;
  } sfrmap_port_t;
endpackage : sfrmap_pkg

// ==== hw/sfrmap_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
module sfrmap_decode (
  input wire logic [7:0] addr, // direct address
  input wire logic sel_map, // area select
  output logic in_window, // address in sfr window
  output logic is_sysreg, // system area control hit
  output logic hit_std, // routed to standard area
  output logic hit_map // routed to mapped area
);
  import sfrmap_pkg::*;
  always_comb begin
    in_window = (addr >= SFRMAP_WIN_BASE);
    is_sysreg = (addr == SFRMAP_SYSAREA_OFS);
    hit_std = in_window && !is_sysreg && !sel_map;
    hit_map = in_window && !is_sysreg && sel_map;
  end
endmodule : sfrmap_decode
`default_nettype wire

// ==== hw/sfrmap_top.sv ====
// Notes on behaviour
// - direct addresses 80h..ffh are register accesses, a window of 128 locations.
// - all architectural registers but the program counter live in that window.
// - two areas, standard and mapped, each span 80h..ffh but 8fh, 255 registers in all with the shared control register.
// - the area is chosen only by the select bit in the system control register at 8fh.
// - select bit one routes to the mapped area, zero to the standard area.
// - the select bit keeps its written value; only reset changes it otherwise.
// - control register resets to 04h, select at bit 0, bit 6 writable, bit 2 reads one, others zero.
`timescale 1ns/10ps
`default_nettype none
module sfrmap_top (
  input wire logic mclk, // core clock
  input wire logic reset, // sync reset, active high
  input wire sfrmap_pkg::sfrmap_req_t cpu_req, // cpu direct access
  output var sfrmap_pkg::sfrmap_port_t std_port_r, // access to standard area
  output var sfrmap_pkg::sfrmap_port_t map_port_r, // access to mapped area
  input wire logic [7:0] std_rdata, // standard area read data
  input wire logic [7:0] map_rdata, // mapped area read data
  output logic [7:0] cpu_rdata_r, // read data to cpu
  output logic rvalid_r, // read data valid pulse
  output logic area_select_bit_r // current area selection
);
  import sfrmap_pkg::*;

  // control register group
  logic [7:0] sysctl_r;
  logic [7:0] sysctl_nxt;
  logic area_select_bit_nxt;
  // routing group
  sfrmap_port_t std_nxt;
  sfrmap_port_t map_nxt;
  // read return group
  logic rd_pend_r;
  logic rd_pend_nxt;
  logic rd_local_r;
  logic rd_local_nxt;
  logic [7:0] local_data_r;
  logic [7:0] local_data_nxt;
  sfrmap_area_t rd_area_r;
  sfrmap_area_t rd_area_nxt;
  logic [7:0] rdata_nxt;
  logic rvalid_nxt;
  // decode results
  logic in_window;
  logic is_sysreg;
  logic hit_std;
  logic hit_map;

  sfrmap_decode u_dec (
    .addr(cpu_req.addr),
    .sel_map(sysctl_r[SFRMAP_SELBIT_POS]),
    .in_window(in_window),
    .is_sysreg(is_sysreg),
    .hit_std(hit_std),
    .hit_map(hit_map)
  );

  function automatic logic [7:0] sysctl_view(input logic [7:0] v);
    sysctl_view = (v & SFRMAP_SYSAREA_RW_MASK) | SFRMAP_SYSAREA_ONE_MASK;
  endfunction : sysctl_view

  // one routed access, strobes only when this area is hit
  function automatic sfrmap_port_t area_access(input sfrmap_req_t req, input logic hit);
    sfrmap_port_t p;
    p = '0;
    p.rd = req.rd && hit;
    p.wr = req.wr && hit;
    p.idx = req.addr[6:0];
    p.wdata = req.wdata;
    return p;
  endfunction : area_access

  // control register: only a write at 8fh moves it
  always_comb begin
    sysctl_nxt = sysctl_r;
    if (cpu_req.wr && is_sysreg) begin
      sysctl_nxt = sysctl_view(cpu_req.wdata);
    end
    area_select_bit_nxt = sysctl_nxt[SFRMAP_SELBIT_POS];
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sysctl_r <= SFRMAP_SYSAREA_RST;
      area_select_bit_r <= SFRMAP_SYSAREA_RST[SFRMAP_SELBIT_POS];
    end else begin
      sysctl_r <= sysctl_nxt;
      area_select_bit_r <= area_select_bit_nxt;
    end
  end

  // routing: area taken from the stored select bit only
  always_comb begin
    std_nxt = area_access(cpu_req, hit_std);
    map_nxt = area_access(cpu_req, hit_map);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      std_port_r <= '0;
      map_port_r <= '0;
    end else begin
      std_port_r <= std_nxt;
      map_port_r <= map_nxt;
    end
  end

  // every read answers two edges after it is taken, so a local read
  // right behind an area read cannot collide with its answer
  always_comb begin
    rd_pend_nxt = cpu_req.rd;
    rd_local_nxt = is_sysreg || !in_window;
    local_data_nxt = is_sysreg ? sysctl_view(sysctl_r) : 8'h00;
    rd_area_nxt = hit_map ? SFRMAP_AREA_MAP : SFRMAP_AREA_STD;
    rdata_nxt = cpu_rdata_r;
    rvalid_nxt = 1'b0;
    if (rd_pend_r) begin
      rvalid_nxt = 1'b1;
      if (rd_local_r) begin
        rdata_nxt = local_data_r;
      end else if (rd_area_r == SFRMAP_AREA_MAP) begin
        rdata_nxt = map_rdata;
      end else begin
        rdata_nxt = std_rdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_pend_r <= 1'b0;
      rd_local_r <= 1'b0;
      local_data_r <= 8'h00;
      rd_area_r <= SFRMAP_AREA_STD;
      cpu_rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rd_pend_r <= rd_pend_nxt;
      rd_local_r <= rd_local_nxt;
      local_data_r <= local_data_nxt;
      rd_area_r <= rd_area_nxt;
      cpu_rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  a_sel_holds: assert property (@(posedge mclk) disable iff (reset)
    !(cpu_req.wr && is_sysreg) |=> $stable(sysctl_r))
    else $error("select bit changed without a write");
  a_std_route: assert property (@(posedge mclk) disable iff (reset)
    (cpu_req.rd && in_window && !is_sysreg && !sysctl_r[0]) |=> std_port_r.rd && !map_port_r.rd)
    else $error("standard access misrouted");
  a_map_route: assert property (@(posedge mclk) disable iff (reset)
    (cpu_req.wr && in_window && !is_sysreg && sysctl_r[0]) |=> map_port_r.wr && !std_port_r.wr)
    else $error("mapped access misrouted");
  a_low_ignored: assert property (@(posedge mclk) disable iff (reset)
    (cpu_req.addr < 8'h80) |=>
      !std_port_r.rd && !std_port_r.wr && !map_port_r.rd && !map_port_r.wr)
    else $error("access below window routed");
  a_fixed_bits: assert property (@(posedge mclk) disable iff (reset)
    (sysctl_r & 8'hbe) == 8'h04)
    else $error("reserved bits wrong");
  a_sys_both: assert property (@(posedge mclk) disable iff (reset)
    (cpu_req.wr && cpu_req.addr == 8'h8f) |=> sysctl_r[0] == $past(cpu_req.wdata[0]))
    else $error("control write lost");
  a_idx_keep: assert property (@(posedge mclk) disable iff (reset)
    (cpu_req.rd && cpu_req.addr > 8'h8f) |=>
      (std_port_r.idx | map_port_r.idx) == $past(cpu_req.addr[6:0]))
    else $error("index mismatch");
  a_rd_answer: assert property (@(posedge mclk) disable iff (reset)
    (cpu_req.rd && in_window) |-> ##2 rvalid_r)
    else $error("read unanswered");

  // read return checks
  a_rd_local: assert property (@(posedge mclk) disable iff (reset)
    (cpu_req.rd && !in_window) |-> ##2 (rvalid_r && cpu_rdata_r == 8'h00))
    else $error("read below window not zero");
  a_sys_read: assert property (@(posedge mclk) disable iff (reset)
    (cpu_req.rd && is_sysreg) |-> ##2 (rvalid_r && cpu_rdata_r == $past(sysctl_r, 2)))
    else $error("control read wrong");
  a_rd_area_std: assert property (@(posedge mclk) disable iff (reset)
    (cpu_req.rd && hit_std) |-> ##2 (rvalid_r && cpu_rdata_r == $past(std_rdata)))
    else $error("standard read data lost");
  a_rd_area_map: assert property (@(posedge mclk) disable iff (reset)
    (cpu_req.rd && hit_map) |-> ##2 (rvalid_r && cpu_rdata_r == $past(map_rdata)))
    else $error("mapped read data lost");
  a_rvalid_src: assert property (@(posedge mclk) disable iff (reset)
    rvalid_r |-> $past(cpu_req.rd, 2))
    else $error("answer without a read");

  // routing checks
  a_sys_unrouted: assert property (@(posedge mclk) disable iff (reset)
    (cpu_req.addr == SFRMAP_SYSAREA_OFS) |=>
      !(std_port_r.rd || std_port_r.wr || map_port_r.rd || map_port_r.wr))
    else $error("control address routed to an area");
  a_std_write: assert property (@(posedge mclk) disable iff (reset)
    (cpu_req.wr && hit_std) |=>
      (std_port_r.wr && !map_port_r.wr && std_port_r.wdata == $past(cpu_req.wdata)))
    else $error("standard write lost");
  a_map_read: assert property (@(posedge mclk) disable iff (reset)
    (cpu_req.rd && hit_map) |=> (map_port_r.rd && !std_port_r.rd))
    else $error("mapped read misrouted");
  a_wr_idx: assert property (@(posedge mclk) disable iff (reset)
    cpu_req.wr |=>
      (std_port_r.idx == $past(cpu_req.addr[6:0]) && map_port_r.idx == $past(cpu_req.addr[6:0])))
    else $error("write index lost");
  a_one_area: assert property (@(posedge mclk) disable iff (reset)
    !((std_port_r.rd || std_port_r.wr) && (map_port_r.rd || map_port_r.wr)))
    else $error("both areas strobed");
  a_idle_quiet: assert property (@(posedge mclk) disable iff (reset)
    !(cpu_req.rd || cpu_req.wr) |=>
      !(std_port_r.rd || std_port_r.wr || map_port_r.rd || map_port_r.wr))
    else $error("strobe without request");

  // control register checks
  a_sel_mirror: assert property (@(posedge mclk) disable iff (reset)
    area_select_bit_r == sysctl_r[SFRMAP_SELBIT_POS])
    else $error("select output differs from register");
  a_sel_only: assert property (@(posedge mclk) disable iff (reset)
    $changed(area_select_bit_r) |-> $past(cpu_req.wr && is_sysreg))
    else $error("select changed without a write");
  a_rw_bits: assert property (@(posedge mclk) disable iff (reset)
    (cpu_req.wr && is_sysreg) |=>
      ((sysctl_r & SFRMAP_SYSAREA_RW_MASK) == ($past(cpu_req.wdata) & SFRMAP_SYSAREA_RW_MASK)))
    else $error("writable bits not taken");
  a_rst_value: assert property (@(posedge mclk) disable iff (reset)
    $fell(reset) |-> (sysctl_r == SFRMAP_SYSAREA_RST && !area_select_bit_r))
    else $error("control register reset value wrong");
endmodule : sfrmap_top
`default_nettype wire

// ==== testbench/sfrmap_area_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sfrmap_area_model #(
  parameter logic [7:0] SALT = 8'h3c
) (
  input wire logic mclk, // core clock
  input wire sfrmap_pkg::sfrmap_port_t port, // routed access
  output logic [7:0] rdata // read answer
);
  import sfrmap_pkg::*;
  logic [7:0] mem [128];
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ SALT;
  end
  always @(posedge mclk) begin
    if (port.wr) mem[port.idx] <= port.wdata;
  end
  // not selected: inverse, so a stale value never passes
  assign rdata = port.rd ? mem[port.idx] : ~mem[port.idx];
endmodule : sfrmap_area_model
`default_nettype wire

// ==== testbench/tb_sfr_area_map_select.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_sfr_area_map_select;
  import sfrmap_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  sfrmap_req_t cpu_req = '0;
  sfrmap_port_t std_port_r, map_port_r;
  logic [7:0] std_rdata, map_rdata, cpu_rdata_r, q;
  logic rvalid_r, area_select_bit_r;
  int num_errors = 0;
  int tests_run = 0;
  always #12.5 mclk = ~mclk;
  sfrmap_top uut (.mclk(mclk), .reset(reset), .cpu_req(cpu_req), .std_port_r(std_port_r),
    .map_port_r(map_port_r), .std_rdata(std_rdata), .map_rdata(map_rdata),
    .cpu_rdata_r(cpu_rdata_r), .rvalid_r(rvalid_r), .area_select_bit_r(area_select_bit_r));
  sfrmap_area_model #(.SALT(8'h3c)) std_m (.mclk(mclk), .port(std_port_r), .rdata(std_rdata));
  sfrmap_area_model #(.SALT(8'hc5)) map_m (.mclk(mclk), .port(map_port_r), .rdata(map_rdata));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] rd_q);
    rd_q = 8'h00;
    @(posedge mclk);
    cpu_req <= '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge mclk);
    cpu_req <= '0;
    for (int n = 0; r && n < 4; n++) begin
      @(posedge mclk);
      #1;
      if (rvalid_r === 1'b1) begin
        rd_q = cpu_rdata_r;
        break;
      end
    end
  endtask : acc
  task automatic do_reset();
    @(posedge mclk);
    reset <= 1'b1;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
  endtask : do_reset
  task automatic t_reset_vals();
    acc(1'b1, SFRMAP_SYSAREA_OFS, 8'h00, q);
    chk(q, 8'h04);
    chk({7'h00, area_select_bit_r}, 8'h00);
  endtask : t_reset_vals
  task automatic t_std_area();
    acc(1'b0, 8'ha0, 8'h5a, q);
    acc(1'b1, 8'ha0, 8'h00, q);
    chk(q, 8'h5a);
    acc(1'b1, 8'h7f, 8'h00, q);
    chk(q, 8'h00);
    acc(1'b1, 8'hff, 8'h00, q);
    chk(q, 8'h7f ^ 8'h3c);
  endtask : t_std_area
  task automatic t_switch();
    acc(1'b1, 8'h8f, 8'h00, q);
    acc(1'b0, 8'h8f, q | 8'h01, q);
    repeat (20) @(posedge mclk);
    #1;
    chk({7'h00, area_select_bit_r}, 8'h01);
    acc(1'b1, 8'ha0, 8'h00, q);
    chk(q, 8'h20 ^ 8'hc5);
    acc(1'b1, 8'h8f, 8'h00, q);
    chk(q, 8'h05);
    acc(1'b0, 8'h8f, 8'hff, q);
    acc(1'b1, 8'h8f, 8'h00, q);
    chk(q, 8'h45);
    acc(1'b0, 8'h8f, q & 8'hfe, q);
    acc(1'b1, 8'ha0, 8'h00, q);
    chk(q, 8'h5a);
  endtask : t_switch
  task automatic t_back2back();
    @(posedge mclk);
    cpu_req <= '{rd: 1'b1, wr: 1'b0, addr: 8'hff, wdata: 8'h00};
    @(posedge mclk);
    cpu_req <= '{rd: 1'b1, wr: 1'b0, addr: SFRMAP_SYSAREA_OFS, wdata: 8'h00};
    @(posedge mclk);
    cpu_req <= '0;
    #1;
    chk({7'h00, rvalid_r}, 8'h01);
    chk(cpu_rdata_r, 8'h7f ^ 8'h3c);
    @(posedge mclk);
    #1;
    chk({7'h00, rvalid_r}, 8'h01);
    chk(cpu_rdata_r, SFRMAP_SYSAREA_RST);
  endtask : t_back2back
  task automatic test_done();
    $display("errors=%0d compares=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial begin
    do_reset();
    t_reset_vals();
    t_std_area();
    t_switch();
    do_reset();
    t_reset_vals();
    t_back2back();
    test_done();
  end
  initial begin
    #50000;
    num_errors++;
    test_done();
  end
endmodule : tb_sfr_area_map_select
`default_nettype wire
